// [hw/fbcs_pkg.sv]
// constants for the feature and block count setup command block
// Operation
// - Feature command raises busy, latches features, then clears busy, raises interrupt.
// - Unsupported or invalid feature subcode posts an aborted-command error.
// - Identify word 94 low byte reports acoustic level, high byte zero.
// - Count byte splits into five-bit transfer type and three-bit mode.
// - PIO mode 4 and multiword DMA 2 work without any mode selection.
// - Unsupported transfer-mode selector aborts the command.
// - Accept 00 as default PIO, 08 to 0C as PIO flow modes 0-4.
// - Accept 20 to 22 as multiword DMA modes 0 to 2.
// - Accept 40 to 45 as Ultra DMA modes 0 to 5.
// - Subcode 42 enables acoustic management at the level in count.
// - Level classes: FF reserved, C0-FE fast, 80-BF quiet, 01-7F retired.
// - Acoustic enable and level survive power-on, hardware and software resets; here the power-on reset i_rst_n clears both.
// - Subcode C2 disables acoustic management, zeroing word 94 low, word 86 bit 9; here no word 86 is output.
// - Opcode C6 is the block count setting command.
// - Supported block counts are 2, 4, 8 and 16 sectors.
// - Block-count command raises busy; valid count stored, multiple mode enabled.
// - Unsupported block count aborts and disables multiple mode.
// - Zero block count disables multiple mode.
// - Block-count completion clears busy and asserts interrupt.
// - Power-on or hardware reset leaves multiple mode disabled.
// - Software reset keeps multiple mode and block count.
// - Identify word 47 reads 8010, sixteen sectors per interrupt maximum.
// - Word 59 reads 0000 disabled, else 01 high and count low.
package fbcs_pkg;
   // task file offsets
   localparam logic [8:0] OFS_FEATURES_OR_ERROR = 9'h1f1;
   localparam logic [8:0] OFS_SECTOR_COUNT = 9'h1f2;
   localparam logic [8:0] OFS_SECTOR_NUMBER = 9'h1f3;
   localparam logic [8:0] OFS_CYLINDER_LOW = 9'h1f4;
   localparam logic [8:0] OFS_CYLINDER_HIGH = 9'h1f5;
   localparam logic [8:0] OFS_DRIVE_HEAD_SELECT = 9'h1f6;
   localparam logic [8:0] OFS_COMMAND_OR_STATUS = 9'h1f7;
   // opcodes
   localparam logic [7:0] OPC_SET_FEATURE = 8'hef;
   localparam logic [7:0] OPC_SET_BLOCK_COUNT = 8'hc6;
   // feature subcodes handled beyond plain acceptance
   localparam logic [7:0] SUB_XFER_MODE = 8'h03;
   localparam logic [7:0] SUB_AAM_ENABLE = 8'h42;
   localparam logic [7:0] SUB_AAM_DISABLE = 8'hc2;
   // transfer type field values, upper five bits of the count
   localparam logic [4:0] XT_PIO_DEFAULT = 5'h00;
   localparam logic [4:0] XT_PIO_FLOW = 5'h01;
   localparam logic [4:0] XT_MW_DMA = 5'h04;
   localparam logic [4:0] XT_ULTRA_DMA = 5'h08;
   localparam logic [2:0] MAX_PIO_FLOW_MODE = 3'h4;
   localparam logic [2:0] MAX_MW_DMA_MODE = 3'h2;
   localparam logic [2:0] MAX_ULTRA_DMA_MODE = 3'h5;
   // acoustic level class boundaries
   localparam logic [7:0] AAM_RESERVED = 8'hff;
   localparam logic [7:0] AAM_FAST_LOW = 8'hc0;
   localparam logic [7:0] AAM_QUIET_LOW = 8'h80;
   localparam logic [7:0] AAM_RETIRED_LOW = 8'h01;
   localparam logic [7:0] AAM_RESET_LEVEL = 8'h00;
   // status and error bits
   localparam int ST_BUSY_BIT = 7;
   localparam int ST_READY_BIT = 6;
   localparam int ST_ERR_BIT = 0;
   localparam int ER_ABORT_BIT = 2;
   localparam logic [7:0] ER_ABORT = 8'h04;
   // identify words
   localparam logic [15:0] ID_WORD47 = 16'h8010;
   localparam logic [7:0] ID_WORD59_ON = 8'h01;
   localparam logic [7:0] XFER_RESET = 8'h00;
   typedef enum logic [2:0] {
      FBCS_IDLE = 3'b001,
      FBCS_EXEC = 3'b010,
      FBCS_DONE = 3'b100
   } fbcs_state_t;
endpackage : fbcs_pkg

// [hw/fbcs_core.sv]
// feature and block count setup: task file registers and command handling
module fbcs_core
   import fbcs_pkg::*;
(
   // clock, reset, enable
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // reset requests from the interface
   input wire logic i_hard_reset,
   input wire logic i_soft_reset,
   // task file access
   input wire logic [8:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic o_intrq,
   // settings towards the transfer engines
   output logic [4:0] o_xfer_type,
   output logic [2:0] o_xfer_mode,
   output logic o_multi_enabled,
   output logic [7:0] o_block_count,
   output logic o_aam_enabled,
   output logic [1:0] o_aam_class,
   // identify data words
   output logic [15:0] o_id_word47,
   output logic [15:0] o_id_word59,
   output logic [15:0] o_id_word94
);

   fbcs_state_t state;
   fbcs_state_t next_state;

   logic [7:0] feature_code_reg;
   logic [7:0] fault_info_reg;
   logic [7:0] count_reg;
   logic [7:0] sector_number;
   logic [7:0] cylinder_low;
   logic [7:0] cylinder_high;
   logic [7:0] unit_head_reg;
   logic [7:0] opcode_reg;
   logic busy;
   logic err;
   logic multi_en;
   logic [7:0] block_cnt;
   logic aam_en;
   logic [7:0] aam_level;
   logic [7:0] xfer_code;

   logic cmd_start;
   logic tf_write;
   logic cmd_abort;
   logic feat_ok;
   logic xfer_ok;
   logic blk_ok;

   // the host may only write the task file while busy is low
   assign tf_write = i_ce && i_wr && !busy;
   assign cmd_start = tf_write && (i_addr == OFS_COMMAND_OR_STATUS);

   // selector check: type in upper bits, mode number in lower bits
   function automatic logic xfer_valid(input logic [7:0] code);
      logic [4:0] xt;
      logic [2:0] md;
      xt = code[7:3];
      md = code[2:0];
      case (xt)
         XT_PIO_DEFAULT: xfer_valid = (md == 3'h0);
         XT_PIO_FLOW: xfer_valid = (md <= MAX_PIO_FLOW_MODE);
         XT_MW_DMA: xfer_valid = (md <= MAX_MW_DMA_MODE);
         XT_ULTRA_DMA: xfer_valid = (md <= MAX_ULTRA_DMA_MODE);
         default: xfer_valid = 1'b0;
      endcase
   endfunction : xfer_valid

   // subcodes that the device recognises, most of them as no-operation
   function automatic logic feature_known(input logic [7:0] sub);
      case (sub)
         8'h02, 8'h03, 8'h04, 8'h05, 8'h33, 8'h42, 8'h54, 8'h55,
         8'h66, 8'h77, 8'h81, 8'h82, 8'h84, 8'h85, 8'h88, 8'h89,
         8'haa, 8'hab, 8'hbb, 8'hc2, 8'hcc: feature_known = 1'b1;
         default: feature_known = 1'b0;
      endcase
   endfunction : feature_known

   function automatic logic block_valid(input logic [7:0] cnt);
      case (cnt)
         8'h02, 8'h04, 8'h08, 8'h10: block_valid = 1'b1;
         default: block_valid = 1'b0;
      endcase
   endfunction : block_valid

   assign xfer_ok = xfer_valid(count_reg);
   assign blk_ok = block_valid(count_reg);
   // unknown subcode, or a transfer mode request with a bad selector
   assign feat_ok = feature_known(feature_code_reg) &&
      ((feature_code_reg != SUB_XFER_MODE) || xfer_ok);

   always_comb begin
      cmd_abort = 1'b1;
      case (opcode_reg)
         OPC_SET_FEATURE: cmd_abort = !feat_ok;
         // zero count disables without error
         OPC_SET_BLOCK_COUNT: cmd_abort = !blk_ok && (count_reg != 8'h00);
         default: cmd_abort = 1'b1;
      endcase
   end

   // command sequencer
   always_comb begin
      next_state = state;
      case (state)
         FBCS_IDLE: begin
            if (cmd_start) begin
               next_state = FBCS_EXEC;
            end
         end
         FBCS_EXEC: next_state = FBCS_DONE;
         // busy is already low here, so a new command may land now;
         // going idle regardless would leave busy stuck high
         FBCS_DONE: begin
            if (cmd_start) begin
               next_state = FBCS_EXEC;
            end else begin
               next_state = FBCS_IDLE;
            end
         end
         default: next_state = FBCS_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= FBCS_IDLE;
      end else if (i_ce) begin
         if (i_hard_reset || i_soft_reset) begin
            state <= FBCS_IDLE;
         end else begin
            state <= next_state;
         end
      end
   end

   // busy rises with the command write and falls on completion
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy <= 1'b0;
      end else if (i_ce) begin
         if (i_hard_reset || i_soft_reset) begin
            busy <= 1'b0;
         end else if (cmd_start) begin
            busy <= 1'b1;
         end else if (state == FBCS_EXEC) begin
            busy <= 1'b0;
         end
      end
   end

   // plain task file registers, host written
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         feature_code_reg <= 8'h00;
         count_reg <= 8'h00;
         sector_number <= 8'h00;
         cylinder_low <= 8'h00;
         cylinder_high <= 8'h00;
         unit_head_reg <= 8'h00;
         opcode_reg <= 8'h00;
      end else if (tf_write) begin
         case (i_addr)
            OFS_FEATURES_OR_ERROR: feature_code_reg <= i_wdata;
            OFS_SECTOR_COUNT: count_reg <= i_wdata;
            OFS_SECTOR_NUMBER: sector_number <= i_wdata;
            OFS_CYLINDER_LOW: cylinder_low <= i_wdata;
            OFS_CYLINDER_HIGH: cylinder_high <= i_wdata;
            OFS_DRIVE_HEAD_SELECT: unit_head_reg <= i_wdata;
            OFS_COMMAND_OR_STATUS: opcode_reg <= i_wdata;
            default: ;
         endcase
      end
   end

   // error bit and error register follow the result of each command
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         err <= 1'b0;
         fault_info_reg <= 8'h00;
      end else if (i_ce) begin
         if (i_hard_reset || i_soft_reset) begin
            err <= 1'b0;
            fault_info_reg <= 8'h00;
         end else if (cmd_start) begin
            err <= 1'b0;
            fault_info_reg <= 8'h00;
         end else if (state == FBCS_EXEC && cmd_abort) begin
            err <= 1'b1;
            fault_info_reg <= ER_ABORT;
         end
      end
   end

   // interrupt: raised at completion, withdrawn by a status read or
   // a new command; a completion in the same cycle as a read wins
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_intrq <= 1'b0;
      end else if (i_ce) begin
         if (i_hard_reset || i_soft_reset) begin
            o_intrq <= 1'b0;
         end else if (state == FBCS_EXEC) begin
            o_intrq <= 1'b1;
         end else if (cmd_start) begin
            o_intrq <= 1'b0;
         end else if (i_rd && i_addr == OFS_COMMAND_OR_STATUS) begin
            o_intrq <= 1'b0;
         end
      end
   end

   // selected transfer mode; engines run pio 4 and mw dma 2 whatever it says
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         xfer_code <= XFER_RESET;
      end else if (i_ce && state == FBCS_EXEC && !cmd_abort &&
            opcode_reg == OPC_SET_FEATURE &&
            feature_code_reg == SUB_XFER_MODE) begin
         xfer_code <= count_reg;
      end
   end

   // multiple mode: cleared by power-on and hardware reset and by a refused or zero block count
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         multi_en <= 1'b0;
         block_cnt <= 8'h00;
      end else if (i_ce) begin
         if (i_hard_reset) begin
            multi_en <= 1'b0;
            block_cnt <= 8'h00;
         end else if (i_soft_reset) begin
            multi_en <= multi_en;
         end else if (state == FBCS_EXEC &&
               opcode_reg == OPC_SET_BLOCK_COUNT) begin
            if (blk_ok) begin
               multi_en <= 1'b1;
               block_cnt <= count_reg;
            end else begin
               multi_en <= 1'b0;
            end
         end
      end
   end

   // acoustic settings: no synchronous reset touches them; only the
   // async power rail reset can, since flops keep nothing without power
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aam_en <= 1'b0;
         aam_level <= AAM_RESET_LEVEL;
      end else if (i_ce && state == FBCS_EXEC && !cmd_abort &&
            opcode_reg == OPC_SET_FEATURE) begin
         if (feature_code_reg == SUB_AAM_ENABLE) begin
            aam_en <= 1'b1;
            aam_level <= count_reg;
         end else if (feature_code_reg == SUB_AAM_DISABLE) begin
            aam_en <= 1'b0;
            aam_level <= AAM_RESET_LEVEL;
         end
      end
   end

   // read port, one cycle latency
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 8'h00;
      end else if (i_ce && i_rd) begin
         case (i_addr)
            OFS_FEATURES_OR_ERROR: o_rdata <= fault_info_reg;
            OFS_SECTOR_COUNT: o_rdata <= count_reg;
            OFS_SECTOR_NUMBER: o_rdata <= sector_number;
            OFS_CYLINDER_LOW: o_rdata <= cylinder_low;
            OFS_CYLINDER_HIGH: o_rdata <= cylinder_high;
            OFS_DRIVE_HEAD_SELECT: o_rdata <= unit_head_reg;
            OFS_COMMAND_OR_STATUS: begin
               o_rdata <= 8'h00;
               o_rdata[ST_BUSY_BIT] <= busy || cmd_start;
               o_rdata[ST_READY_BIT] <= !(busy || cmd_start);
               o_rdata[ST_ERR_BIT] <= err;
            end
            default: o_rdata <= 8'h00;
         endcase
      end
   end

   // settings towards the engines, registered copies of the live state
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_xfer_type <= 5'h00;
         o_xfer_mode <= 3'h0;
         o_multi_enabled <= 1'b0;
         o_block_count <= 8'h00;
         o_aam_enabled <= 1'b0;
      end else if (i_ce) begin
         o_xfer_type <= xfer_code[7:3];
         o_xfer_mode <= xfer_code[2:0];
         o_multi_enabled <= multi_en;
         o_block_count <= block_cnt;
         o_aam_enabled <= aam_en;
      end
   end

   // level class, updated in the same cycle as the identify copy
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_aam_class <= 2'h0;
      end else if (i_ce) begin
         // 0 vendor fast, 1 quiet, 2 fast, 3 reserved or retired
         if (aam_level == AAM_RESERVED) begin
            o_aam_class <= 2'h3;
         end else if (aam_level >= AAM_FAST_LOW) begin
            o_aam_class <= 2'h2;
         end else if (aam_level >= AAM_QUIET_LOW) begin
            o_aam_class <= 2'h1;
         end else if (aam_level >= AAM_RETIRED_LOW) begin
            o_aam_class <= 2'h3;
         end else begin
            o_aam_class <= 2'h0;
         end
      end
   end

   // identify words
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_id_word47 <= ID_WORD47;
         o_id_word59 <= 16'h0000;
         o_id_word94 <= 16'h0000;
      end else if (i_ce) begin
         o_id_word47 <= ID_WORD47;
         o_id_word59 <= multi_en ? {ID_WORD59_ON, block_cnt}
            : 16'h0000;
         o_id_word94 <= {8'h00, aam_level};
      end
   end

endmodule : fbcs_core

// [testbench/fbcs_core_chk.sv]
// port-level assertions for the feature and block count setup block
module fbcs_core_chk
   import fbcs_pkg::*;
(
   // clock and resets
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_hard_reset,
   input wire logic i_soft_reset,
   // task file
   input wire logic [8:0] i_addr,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   input wire logic o_intrq,
   // settings and identify words
   input wire logic [4:0] o_xfer_type,
   input wire logic [2:0] o_xfer_mode,
   input wire logic o_multi_enabled,
   input wire logic o_aam_enabled,
   input wire logic [1:0] o_aam_class,
   input wire logic [15:0] o_id_word47,
   input wire logic [15:0] o_id_word59,
   input wire logic [15:0] o_id_word94
);
   timeunit 1ns;
   timeprecision 1ps;
   logic bsy;
   logic [7:0] fr_q;
   logic [7:0] cnt_q;
   logic wok;
   logic acc;
   logic sel_ok;
   logic blk_ok;
   logic [7:0] lv;
   logic [1:0] cls;
   assign wok = i_ce && i_wr && !bsy;
   assign acc = wok && i_addr == OFS_COMMAND_OR_STATUS;
   assign sel_ok = cnt_q == 8'h00
      || (cnt_q[7:3] == 5'h01 && cnt_q[2:0] <= 3'h4)
      || (cnt_q[7:3] == 5'h04 && cnt_q[2:0] <= 3'h2)
      || (cnt_q[7:3] == 5'h08 && cnt_q[2:0] <= 3'h5);
   assign blk_ok = cnt_q == 8'h02 || cnt_q == 8'h04 || cnt_q == 8'h08
      || cnt_q == 8'h10;
   assign lv = o_id_word94[7:0];
   assign cls = (lv == 8'h00) ? 2'h0 : (lv[7:6] == 2'b10) ? 2'h1 :
      (lv[7:6] == 2'b11 && lv != 8'hff) ? 2'h2 : 2'h3;
   // mirrors the busy cycle so refused writes are not taken as commands
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bsy <= 1'b0;
         fr_q <= 8'h00;
         cnt_q <= 8'h00;
      end else if (i_ce) begin
         bsy <= acc && !i_hard_reset && !i_soft_reset;
         if (wok && i_addr == OFS_FEATURES_OR_ERROR) fr_q <= i_wdata;
         if (wok && i_addr == OFS_SECTOR_COUNT) cnt_q <= i_wdata;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n || i_hard_reset || i_soft_reset);
   sequence s_feat_xfer;
      acc && i_wdata == OPC_SET_FEATURE && fr_q == SUB_XFER_MODE;
   endsequence
   sequence s_xfer_ok; s_feat_xfer ##0 sel_ok; endsequence
   sequence s_xfer_bad; s_feat_xfer ##0 !sel_ok; endsequence
   sequence s_blk_ok;
      acc && i_wdata == OPC_SET_BLOCK_COUNT && blk_ok;
   endsequence
   sequence s_blk_bad;
      acc && i_wdata == OPC_SET_BLOCK_COUNT && !blk_ok;
   endsequence
   sequence s_aam_on;
      acc && i_wdata == OPC_SET_FEATURE && fr_q == SUB_AAM_ENABLE;
   endsequence
   sequence s_aam_off;
      acc && i_wdata == OPC_SET_FEATURE && fr_q == SUB_AAM_DISABLE;
   endsequence
   property p_irq; acc |=> !o_intrq ##1 o_intrq; endproperty
   a_irq: assert property (p_irq) else $error("late interrupt");
   property p_w47; o_id_word47 == ID_WORD47; endproperty
   a_w47: assert property (p_w47) else $error("bad word 47");
   property p_w94hi; o_id_word94[15:8] == 8'h00; endproperty
   a_w94hi: assert property (p_w94hi) else $error("word 94 high");
   property p_cls; o_aam_class == cls; endproperty
   a_cls: assert property (p_cls) else $error("bad level class");
   property p_blk_ok;
      s_blk_ok |-> ##3 o_multi_enabled &&
         o_id_word59 == {8'h01, $past(cnt_q, 3)};
   endproperty
   a_blk_ok: assert property (p_blk_ok)
      else $error("count not taken");
   property p_blk_bad;
      s_blk_bad |-> ##3 !o_multi_enabled && o_id_word59 == 16'h0000;
   endproperty
   a_blk_bad: assert property (p_blk_bad)
      else $error("multi left on");
   property p_xfer_ok;
      s_xfer_ok |-> ##3 {o_xfer_type, o_xfer_mode} == $past(cnt_q, 3);
   endproperty
   a_xfer_ok: assert property (p_xfer_ok)
      else $error("mode not taken");
   property p_xfer_bad;
      s_xfer_bad |-> ##3 $stable({o_xfer_type, o_xfer_mode}) [*2];
   endproperty
   a_xfer_bad: assert property (p_xfer_bad)
      else $error("bad mode taken");
   property p_aam_on;
      s_aam_on |-> ##3 o_aam_enabled &&
         o_id_word94 == {8'h00, $past(cnt_q, 3)};
   endproperty
   a_aam_on: assert property (p_aam_on)
      else $error("level not taken");
   property p_aam_off;
      s_aam_off |-> ##3 !o_aam_enabled && o_id_word94 == 16'h0000;
   endproperty
   a_aam_off: assert property (p_aam_off) else $error("level kept");
endmodule : fbcs_core_chk

bind fbcs_core fbcs_core_chk fbcs_core_chk_inst (.i_core_clk, .i_rst_n, .i_ce,
   .i_hard_reset, .i_soft_reset, .i_addr, .i_wr, .i_wdata, .o_intrq,
   .o_xfer_type, .o_xfer_mode, .o_multi_enabled, .o_aam_enabled, .o_aam_class,
   .o_id_word47, .o_id_word59, .o_id_word94);

// [testbench/fbcs_host.sv]
// host adapter model driving the task file
module fbcs_host
   import fbcs_pkg::*;
(
   // clock and read data
   input wire logic i_core_clk,
   input wire logic [7:0] i_rdata,
   // task file drive
   output logic [8:0] o_addr = 9'h000,
   output logic o_wr = 1'b0,
   output logic o_rd = 1'b0,
   output logic [7:0] o_wdata = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   // every task starts and ends on a rising edge
   task wr(input logic [8:0] a, input logic [7:0] v);
      o_addr <= a;
      o_wdata <= v;
      o_wr <= 1'b1;
      o_rd <= 1'b0;
      @(posedge i_core_clk);
   endtask : wr
   // write data is scrambled during reads, so nothing leans on it
   task rd(input logic [8:0] a, output logic [7:0] v);
      o_addr <= a;
      o_wr <= 1'b0;
      o_rd <= 1'b1;
      o_wdata <= ~o_wdata;
      @(posedge i_core_clk);
      o_rd <= 1'b0;
      @(posedge i_core_clk);
      v = i_rdata;
   endtask : rd
   task idle();
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      @(posedge i_core_clk);
   endtask : idle
   task issue(input logic [7:0] f, input logic [7:0] c, input logic [7:0] op);
      wr(OFS_FEATURES_OR_ERROR, f);
      wr(OFS_SECTOR_COUNT, c);
      wr(OFS_COMMAND_OR_STATUS, op);
   endtask : issue
endmodule : fbcs_host

// [testbench/testbench.sv]
// self-checking bench for the feature and block count setup block
`define CHK(a, b) begin \
   total_checks++; \
   if ((a) !== (b)) begin \
      miscompares++; \
      $display("[ERR] %0t got %h want %h", $time, (a), (b)); \
   end \
end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import fbcs_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_ce = 1'b1;
   logic i_hard_reset = 1'b0;
   logic i_soft_reset = 1'b0;
   logic [8:0] i_addr;
   logic i_wr, i_rd, o_intrq, o_multi_enabled, o_aam_enabled;
   logic [7:0] i_wdata, o_rdata, o_block_count, c, xs, s, bc;
   logic [4:0] o_xfer_type;
   logic [2:0] o_xfer_mode;
   logic [1:0] o_aam_class;
   logic [15:0] o_id_word47, o_id_word59, o_id_word94;
   logic ok;
   logic [7:0] lv [5] = '{8'h01, 8'h80, 8'hbf, 8'hc0, 8'hfe};
   logic [1:0] cl [5] = '{2'h3, 2'h1, 2'h1, 2'h2, 2'h2};
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   fbcs_core fbcs_core_inst (.i_core_clk, .i_rst_n, .i_ce, .i_hard_reset,
      .i_soft_reset, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .o_intrq,
      .o_xfer_type, .o_xfer_mode, .o_multi_enabled, .o_block_count,
      .o_aam_enabled, .o_aam_class, .o_id_word47, .o_id_word59, .o_id_word94);
   fbcs_host fbcs_host_inst (.i_core_clk, .i_rdata(o_rdata), .o_addr(i_addr),
      .o_wr(i_wr), .o_rd(i_rd), .o_wdata(i_wdata));
   always #10 i_core_clk = ~i_core_clk;
   task give_verdict();
      if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   // about 3150 cycles are needed; the ceiling leaves ample margin
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   task cmd(input logic [7:0] f, input logic [7:0] n, input logic [7:0] op,
      input logic ab);
      fbcs_host_inst.issue(f, n, op);
      fbcs_host_inst.rd(OFS_COMMAND_OR_STATUS, s);
      `CHK(s[7], 1'b1)
      fbcs_host_inst.idle();
      fbcs_host_inst.idle();
      `CHK(o_intrq, 1'b1)
      fbcs_host_inst.rd(OFS_COMMAND_OR_STATUS, s);
      `CHK(s, ab ? 8'h41 : 8'h40)
      `CHK(o_intrq, 1'b0)
      fbcs_host_inst.rd(OFS_FEATURES_OR_ERROR, s);
      `CHK(s, ab ? ER_ABORT : 8'h00)
   endtask : cmd
   task pulse(input logic hard);
      if (hard) i_hard_reset <= 1'b1;
      else i_soft_reset <= 1'b1;
      @(posedge i_core_clk);
      i_hard_reset <= 1'b0;
      i_soft_reset <= 1'b0;
      repeat (3) @(posedge i_core_clk);
   endtask : pulse
   initial begin
      xs = 8'h00;
      bc = 8'h00;
      repeat (8) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      @(posedge i_core_clk);
      `CHK({o_multi_enabled, o_id_word59}, 17'h0)
      `CHK(o_id_word47, ID_WORD47)
      `CHK({o_xfer_type, o_xfer_mode}, XFER_RESET)
      fbcs_host_inst.rd(9'h1f8, s);
      `CHK(s, 8'h00)
      fbcs_host_inst.wr(OFS_SECTOR_NUMBER, 8'h5a);
      fbcs_host_inst.rd(OFS_SECTOR_NUMBER, s);
      `CHK(s, 8'h5a)
      // a write while the enable is low must not land
      i_ce <= 1'b0;
      fbcs_host_inst.wr(OFS_SECTOR_NUMBER, 8'ha5);
      i_ce <= 1'b1;
      fbcs_host_inst.rd(OFS_SECTOR_NUMBER, s);
      `CHK(s, 8'h5a)
      // every selector value, in order, so each refusal must keep the last accepted mode
      for (int i = 0; i < 256; i++) begin
         c = i[7:0];
         ok = c == 8'h00 || (c[7:3] == 5'h01 && c[2:0] <= 3'h4)
            || (c[7:3] == 5'h04 && c[2:0] <= 3'h2)
            || (c[7:3] == 5'h08 && c[2:0] <= 3'h5);
         if (ok) xs = c;
         cmd(SUB_XFER_MODE, c, OPC_SET_FEATURE, !ok);
         `CHK({o_xfer_type, o_xfer_mode}, xs)
      end
      foreach (lv[k]) begin
         cmd(SUB_AAM_ENABLE, lv[k], OPC_SET_FEATURE, 1'b0);
         `CHK({o_aam_enabled, o_id_word94}, {9'h100, lv[k]})
         `CHK(o_aam_class, cl[k])
      end
      cmd(SUB_AAM_DISABLE, 8'h00, OPC_SET_FEATURE, 1'b0);
      `CHK({o_aam_enabled, o_id_word94}, 17'h0)
      cmd(8'h01, 8'h00, OPC_SET_FEATURE, 1'b1);
      cmd(8'h00, 8'h00, 8'h00, 1'b1);
      for (int i = 0; i < 18; i++) begin
         c = i[7:0];
         ok = c == 8'h02 || c == 8'h04 || c == 8'h08 || c == 8'h10;
         if (ok) bc = c;
         cmd(8'h00, c, OPC_SET_BLOCK_COUNT, !ok && |c);
         `CHK(o_multi_enabled, ok)
         `CHK(o_id_word59, ok ? {8'h01, c} : 16'h0000)
         `CHK(o_block_count, bc)
      end
      // a command written in the first cycle after busy drops completes
      fbcs_host_inst.wr(OFS_COMMAND_OR_STATUS, OPC_SET_BLOCK_COUNT);
      fbcs_host_inst.idle();
      fbcs_host_inst.wr(OFS_COMMAND_OR_STATUS, OPC_SET_BLOCK_COUNT);
      fbcs_host_inst.idle();
      fbcs_host_inst.rd(OFS_COMMAND_OR_STATUS, s);
      `CHK(s, 8'h41)
      cmd(8'h00, 8'h08, OPC_SET_BLOCK_COUNT, 1'b0);
      cmd(SUB_AAM_ENABLE, 8'h90, OPC_SET_FEATURE, 1'b0);
      pulse(1'b0);
      `CHK({o_multi_enabled, o_block_count}, 9'h108)
      `CHK({o_id_word59, o_id_word94}, 32'h0108_0090)
      pulse(1'b1);
      `CHK({o_multi_enabled, o_block_count}, 9'h000)
      `CHK({o_id_word59, o_id_word94}, 32'h0000_0090)
      give_verdict();
   end
endmodule : testbench
